// ---- rtl/brs_cfg.svh ----
// Purpose: Constants of the brown-out reset sequencer: offsets, fields, reset values and timings.
// Assumes: Register byte addresses on a 32-bit Avalon-MM slave, clock at 125 MHz.
// Notes: Times are kept in their own unit; cycle counts derive from them and the clock rate.
`ifndef BRS_CFG_SVH
`define BRS_CFG_SVH

`define BRS_CLK_MHZ 125

// Regulator start-up, in microseconds, and its cycle count.
`define BRS_REG_STARTUP_US 20
`define BRS_REG_STARTUP_CYC (`BRS_REG_STARTUP_US * `BRS_CLK_MHZ)

// Nominal fail-safe monitor delay, in microseconds, and its cycle count.
`define BRS_FAILSAFE_US 100
`define BRS_FAILSAFE_CYC (`BRS_FAILSAFE_US * `BRS_CLK_MHZ)

// Oscillator start-up timer length in cycles.
`define BRS_OSC_START_CYC 1024

`define BRS_CNT_W 20
`define BRS_ADDR_W 5
`define BRS_NUM_FLAGS 3

// Register byte addresses.
`define BRS_ADDR_CFG 5'h00
`define BRS_ADDR_PUP_DLY 5'h04
`define BRS_ADDR_CAUSE 5'h08
`define BRS_ADDR_CLR 5'h0C
`define BRS_ADDR_EN 5'h10
`define BRS_ADDR_STATE 5'h14

// Configuration register fields.
`define BRS_CFG_SEL_LSB 0
`define BRS_CFG_MODE_LSB 3
`define BRS_CFG_RESET 5'h00
`define BRS_PUP_DLY_RESET 20'h00000

// Flag positions in the cause, clear and enable registers.
`define BRS_FLG_PWR 0
`define BRS_FLG_BROWN 1
`define BRS_FLG_REL 2

// State register fields.
`define BRS_ST_LOCK_BIT 5
`define BRS_ST_RESET_BIT 0
`define BRS_ST_CLKEN_BIT 1
`define BRS_ST_EXEC_BIT 2
`define BRS_ST_SLEEP_BIT 3
`define BRS_ST_IDLE_BIT 4
`define BRS_ST_FSM_LSB 8

// Clock source decode of the oscillator select field.
`define BRS_SEL_PLL_A 3'h1
`define BRS_SEL_PRI 3'h2
`define BRS_SEL_PRI_PLL 3'h3
`define BRS_SEL_SEC 3'h4
// Primary oscillator modes that use a crystal.
`define BRS_MODE_XT 2'h1
`define BRS_MODE_HS 2'h2

`endif

// ---- rtl/brs_pkg.sv ----
// Purpose: Types shared by the brown-out reset sequencer.
// Assumes: Constants come from brs_cfg.svh.
// Notes: None.
`default_nettype none
`include "brs_cfg.svh"

package brs_pkg;
  typedef enum logic [1:0] {
    BRS_ST_RUN = 2'b00,
    BRS_ST_HOLD = 2'b01,
    BRS_ST_WAIT = 2'b10
  } brs_state_e;

  typedef logic [`BRS_CNT_W-1:0] brs_cnt_t;
  typedef logic [`BRS_NUM_FLAGS-1:0] brs_flags_t;
endpackage : brs_pkg

`default_nettype wire

// ---- rtl/brs_timer.sv ----
// Purpose: Loadable down counter for one start-up delay.
// Assumes: A load with a count of zero gives an expired timer in the cycle after the load.
// Notes: Expired is a level while the count stands at zero and load is low.
`default_nettype none
`include "brs_cfg.svh"

module brs_timer (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic load,
  input wire brs_pkg::brs_cnt_t value,
  output logic expired
);
  import brs_pkg::*;

  brs_cnt_t cnt_r;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cnt_r <= '0;
    end else if (load) begin
      cnt_r <= value;
    end else if (cnt_r != '0) begin
      cnt_r <= cnt_r - `BRS_CNT_W'(1);
    end
  end

  assign expired = (cnt_r == '0) && !load;
endmodule : brs_timer

`default_nettype wire

// ---- rtl/brs_flags.sv ----
// Purpose: Sticky event flags with enable mask and one level interrupt.
// Assumes: Set and clear are one-cycle pulses per bit.
// Notes: A set in the cycle of a clear wins.
`default_nettype none
`include "brs_cfg.svh"

module brs_flags (
  input wire logic ref_clk,
  input wire logic rst,
  input wire brs_pkg::brs_flags_t set,
  input wire brs_pkg::brs_flags_t clr,
  input wire brs_pkg::brs_flags_t enable,
  output brs_pkg::brs_flags_t status,
  output logic irq
);
  import brs_pkg::*;

  brs_flags_t status_r;
  logic irq_r;

  genvar i;
  generate
    for (i = 0; i < `BRS_NUM_FLAGS; i++) begin : g_flag
      always_ff @(posedge ref_clk) begin
        if (rst) begin
          status_r[i] <= 1'b0;
        end else if (set[i]) begin
          status_r[i] <= 1'b1;
        end else if (clr[i]) begin
          status_r[i] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(((status_r & ~clr) | set) & enable);
    end
  end

  assign status = status_r;
  assign irq = irq_r;
endmodule : brs_flags

`default_nettype wire

// ---- rtl/brs_seq.sv ----
// Purpose: Brown-out and power-up reset sequencer with Avalon-MM registers.
// Assumes: All inputs are synchronous to ref_clk; the comparator input is high while the supply is low.
// Notes: The block itself is reset only by rst, so its registers survive the device reset it drives.
//
// How it works
// RQ1 - A brown-out holds the device reset asserted, then runs the release sequence.
// RQ2 - On brown-out the clock source follows oscillator select and primary mode fields.
// RQ3 - With an oscillator mode selected, the start-up timer runs and the clock waits.
// RQ4 - When the PLL is used, the clock also waits for PLL lock high.
// RQ5 - The power-up delay runs alongside the clock hold before reset release.
// RQ6 - Zero power-up delay with a crystal uses the nominal fail-safe delay instead.
// RQ7 - Every brown-out reset sets the brown-out cause bit, bit 1.
// RQ8 - Brown-out detection is never gated by Sleep or Idle.
// RQ9 - After power-on, execution stays disabled for the 20 us regulator start-up.
// RQ10 - The regulator start-up delay follows every resume after power-down as well.
// RQ11 - Reset releases only when clock hold, delay and regulator start-up are all done.
//
// The Avalon-MM register port and the register addresses were chosen for this implementation.
`default_nettype none
`include "brs_cfg.svh"

module brs_seq #(
  parameter int unsigned FSCM_CYC = `BRS_FAILSAFE_CYC,
  parameter int unsigned OSC_START_CYC = `BRS_OSC_START_CYC
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic vdd_low,
  input wire logic power_resume,
  input wire logic sleep_mode,
  input wire logic idle_mode,
  input wire logic pll_lock,
  input wire logic [`BRS_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic core_reset,
  output logic sysclk_en,
  output logic code_exec_en,
  output logic [2:0] clk_src_sel,
  output logic irq
);
  import brs_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Declarations.

  brs_state_e state_r;
  logic core_reset_r;
  logic sysclk_en_r;
  logic code_exec_en_r;
  logic [2:0] clk_src_sel_r;
  logic pll_used_r;
  logic reg_needed_r;
  logic vdd_low_seen_r;
  logic [2:0] osc_select_config_r;
  logic [1:0] primary_osc_mode_config_r;
  brs_cnt_t pup_dly_cycles_r;
  brs_flags_t flag_en_r;
  brs_flags_t flag_set_r;
  brs_flags_t flag_clr;
  brs_flags_t flag_status;
  logic [31:0] avs_readdata_r;
  logic avs_waitrequest_r;
  logic bus_take;
  logic start;
  logic osc_mode;
  logic pll_mode;
  logic crystal;
  logic osc_start_done;
  logic dly_done;
  logic reg_done;
  logic clk_ready;
  brs_cnt_t osc_start_value;
  brs_cnt_t dly_value;
  brs_cnt_t reg_value;

  ////////////////////////////////////////////////////////////////////////////
  // Clock source decode.

  always_comb begin
    pll_mode = (osc_select_config_r == `BRS_SEL_PLL_A) || (osc_select_config_r == `BRS_SEL_PRI_PLL); // RQ2
    osc_mode = (osc_select_config_r == `BRS_SEL_PRI) || (osc_select_config_r == `BRS_SEL_PRI_PLL)
      || (osc_select_config_r == `BRS_SEL_SEC); // RQ2
    crystal = (osc_select_config_r == `BRS_SEL_PRI || osc_select_config_r == `BRS_SEL_PRI_PLL)
      && (primary_osc_mode_config_r == `BRS_MODE_XT || primary_osc_mode_config_r == `BRS_MODE_HS);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Delay timers, loaded together when the supply is good again.

  assign start = (state_r == BRS_ST_HOLD) && !vdd_low;

  always_comb begin
    osc_start_value = osc_mode ? brs_cnt_t'(OSC_START_CYC) : '0; // RQ3
    if (pup_dly_cycles_r == '0 && crystal) begin
      dly_value = brs_cnt_t'(FSCM_CYC); // RQ6
    end else begin
      dly_value = pup_dly_cycles_r; // RQ5
    end
    // The regulator delay is owed only after power-on or a resume.
    reg_value = reg_needed_r ? brs_cnt_t'(`BRS_REG_STARTUP_CYC) : '0; // RQ9 RQ10
  end

  brs_timer u_osc_start (
    .ref_clk(ref_clk),
    .rst(rst),
    .load(start),
    .value(osc_start_value),
    .expired(osc_start_done)
  );

  brs_timer u_dly (
    .ref_clk(ref_clk),
    .rst(rst),
    .load(start),
    .value(dly_value),
    .expired(dly_done)
  );

  brs_timer u_reg (
    .ref_clk(ref_clk),
    .rst(rst),
    .load(start),
    .value(reg_value),
    .expired(reg_done)
  );

  // The clock is held until the start-up timer and, with a PLL, lock.
  assign clk_ready = osc_start_done && (!pll_used_r || pll_lock); // RQ3 RQ4

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer state.

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_r <= BRS_ST_HOLD;
    end else if (vdd_low || power_resume) begin
      // Detection runs whatever the sleep or idle state.
      state_r <= BRS_ST_HOLD; // RQ1 RQ8
    end else begin
      case (state_r)
        BRS_ST_HOLD: state_r <= BRS_ST_WAIT;
        BRS_ST_WAIT: begin
          if (clk_ready && dly_done && reg_done) begin
            state_r <= BRS_ST_RUN; // RQ11
          end
        end
        BRS_ST_RUN: state_r <= BRS_ST_RUN;
        default: state_r <= BRS_ST_HOLD;
      endcase
    end
  end

  // Internal reset and execution enable.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      core_reset_r <= 1'b1;
      code_exec_en_r <= 1'b0;
    end else if (vdd_low || power_resume) begin
      core_reset_r <= 1'b1; // RQ1
      code_exec_en_r <= 1'b0; // RQ9
    end else if (state_r == BRS_ST_WAIT && clk_ready && dly_done && reg_done) begin
      core_reset_r <= 1'b0; // RQ5 RQ11
      code_exec_en_r <= 1'b1; // RQ9 RQ10
    end
  end

  // System clock gate: closed in hold, then it follows clock readiness while waiting.
  // Once running it stays open until the next supply event.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sysclk_en_r <= 1'b0;
    end else if (vdd_low || power_resume || state_r == BRS_ST_HOLD) begin
      sysclk_en_r <= 1'b0; // RQ3
    end else if (state_r == BRS_ST_WAIT) begin
      sysclk_en_r <= clk_ready; // RQ3 RQ4
    end
  end

  // Clock source choice and PLL use, taken as the sequence starts.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      clk_src_sel_r <= 3'h0;
      pll_used_r <= 1'b0;
    end else if (start) begin
      clk_src_sel_r <= osc_select_config_r; // RQ2
      pll_used_r <= pll_mode; // RQ4
    end
  end

  // The regulator delay is owed after power-on and every power resume.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      reg_needed_r <= 1'b1; // RQ9
    end else if (power_resume) begin
      reg_needed_r <= 1'b1; // RQ10
    end else if (start) begin
      reg_needed_r <= 1'b0;
    end
  end

  // One flag pulse per event; the brown-out flag fires on the comparator's rise.
  // The release flag stays clear when a new event lands in the release cycle.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      vdd_low_seen_r <= 1'b0;
      flag_set_r <= '0;
    end else begin
      vdd_low_seen_r <= vdd_low;
      flag_set_r[`BRS_FLG_BROWN] <= vdd_low && !vdd_low_seen_r; // RQ7
      flag_set_r[`BRS_FLG_PWR] <= power_resume;
      flag_set_r[`BRS_FLG_REL] <= state_r == BRS_ST_WAIT && clk_ready && dly_done && reg_done
        && !vdd_low && !power_resume;
    end
  end

  brs_flags u_flags (
    .ref_clk(ref_clk),
    .rst(rst),
    .set(flag_set_r),
    .clr(flag_clr),
    .enable(flag_en_r),
    .status(flag_status),
    .irq(irq)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Avalon-MM slave: one wait cycle, then the access is taken.

  // A request is taken in the cycle in which waitrequest stands low.
  assign bus_take = (avs_read || avs_write) && !avs_waitrequest_r;
  assign flag_clr = (avs_write && bus_take && avs_address == `BRS_ADDR_CLR)
    ? avs_writedata[`BRS_NUM_FLAGS-1:0] : '0;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      avs_waitrequest_r <= 1'b1;
    end else begin
      avs_waitrequest_r <= !((avs_read || avs_write) && avs_waitrequest_r);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      // Both configuration fields leave reset as one all-zero word.
      {primary_osc_mode_config_r, osc_select_config_r} <= `BRS_CFG_RESET;
      pup_dly_cycles_r <= `BRS_PUP_DLY_RESET;
      flag_en_r <= '0;
    end else if (avs_write && bus_take) begin
      case (avs_address)
        `BRS_ADDR_CFG: begin
          osc_select_config_r <= avs_writedata[`BRS_CFG_SEL_LSB +: 3];
          primary_osc_mode_config_r <= avs_writedata[`BRS_CFG_MODE_LSB +: 2];
        end
        `BRS_ADDR_PUP_DLY: pup_dly_cycles_r <= avs_writedata[`BRS_CNT_W-1:0];
        `BRS_ADDR_EN: flag_en_r <= avs_writedata[`BRS_NUM_FLAGS-1:0];
        default: ;
      endcase
    end
  end

  // Read data is loaded in the cycle that waitrequest drops.
  // Unmapped addresses read as zero.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      avs_readdata_r <= 32'h0000_0000;
    end else if (avs_read && avs_waitrequest_r) begin
      avs_readdata_r <= 32'h0000_0000;
      case (avs_address)
        `BRS_ADDR_CFG: begin
          avs_readdata_r[`BRS_CFG_SEL_LSB +: 3] <= osc_select_config_r;
          avs_readdata_r[`BRS_CFG_MODE_LSB +: 2] <= primary_osc_mode_config_r;
        end
        `BRS_ADDR_PUP_DLY: avs_readdata_r[`BRS_CNT_W-1:0] <= pup_dly_cycles_r;
        `BRS_ADDR_CAUSE: avs_readdata_r[`BRS_NUM_FLAGS-1:0] <= flag_status; // RQ7
        `BRS_ADDR_EN: avs_readdata_r[`BRS_NUM_FLAGS-1:0] <= flag_en_r;
        `BRS_ADDR_STATE: begin
          avs_readdata_r[`BRS_ST_RESET_BIT] <= core_reset_r;
          avs_readdata_r[`BRS_ST_CLKEN_BIT] <= sysclk_en_r;
          avs_readdata_r[`BRS_ST_EXEC_BIT] <= code_exec_en_r;
          avs_readdata_r[`BRS_ST_SLEEP_BIT] <= sleep_mode;
          avs_readdata_r[`BRS_ST_IDLE_BIT] <= idle_mode;
          avs_readdata_r[`BRS_ST_LOCK_BIT] <= pll_lock;
          avs_readdata_r[`BRS_ST_FSM_LSB +: 2] <= state_r;
        end
        default: avs_readdata_r <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs.

  assign avs_readdata = avs_readdata_r;
  assign avs_waitrequest = avs_waitrequest_r;
  assign core_reset = core_reset_r;
  assign sysclk_en = sysclk_en_r;
  assign code_exec_en = code_exec_en_r;
  assign clk_src_sel = clk_src_sel_r;
endmodule : brs_seq

`default_nettype wire

// ---- tb/brs_supply_model.sv ----
// Purpose: Far side of the sequencer: supply comparator, resume strobe and PLL lock status.
// Assumes: The bench commands a supply dip or a resume one cycle at a time.
// Notes: The PLL loses lock on any supply event and relocks LOCK_CYC cycles later.
`default_nettype none

module brs_supply_model #(
  parameter int unsigned LOCK_CYC = 12
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic dip,
  input wire logic resume,
  output logic vdd_low,
  output logic power_resume,
  output logic pll_lock
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] lock_cnt_r;
  assign vdd_low = dip;
  assign power_resume = resume;
  assign pll_lock = (lock_cnt_r == 8'h00);
  always_ff @(posedge ref_clk) begin
    if (rst || dip || resume) begin
      lock_cnt_r <= 8'(LOCK_CYC);
    end else if (lock_cnt_r != 8'h00) begin
      lock_cnt_r <= lock_cnt_r - 8'h01;
    end
  end
endmodule : brs_supply_model

`default_nettype wire

// ---- tb/brs_seq_chk.sv ----
// Purpose: Port-level assertions of the reset sequencer.
// Assumes: One clock domain, synchronous active-high reset.
// Notes: Counters measure cycles since the last supply event and since the last regulator restart.
`default_nettype none

module brs_seq_chk #(
  parameter int unsigned FSCM_CYC = 20,
  parameter int unsigned OSC_START_CYC = 8
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic vdd_low,
  input wire logic power_resume,
  input wire logic sleep_mode,
  input wire logic idle_mode,
  input wire logic pll_lock,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic core_reset,
  input wire logic sysclk_en,
  input wire logic code_exec_en,
  input wire logic [2:0] clk_src_sel
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int REG_CYC = 2500;
  logic [15:0] ev_cnt_r;
  logic [15:0] reg_cnt_r;
  always_ff @(posedge ref_clk) begin
    if (rst || vdd_low || power_resume) ev_cnt_r <= 16'h0000;
    else if (ev_cnt_r != 16'hFFFF) ev_cnt_r <= ev_cnt_r + 16'h0001;
  end
  always_ff @(posedge ref_clk) begin
    if (rst || power_resume) reg_cnt_r <= 16'h0000;
    else if (reg_cnt_r != 16'hFFFF) reg_cnt_r <= reg_cnt_r + 16'h0001;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  property p_bor_reset; vdd_low |=> core_reset && !sysclk_en && !code_exec_en; endproperty
  a_bor_reset: assert property (p_bor_reset) else $error("supply dip did not reset");
  property p_sleep; vdd_low && (sleep_mode || idle_mode) |=> core_reset; endproperty
  a_sleep: assert property (p_sleep) else $error("dip in low power ignored");
  property p_src; $changed(clk_src_sel) |-> core_reset; endproperty
  a_src: assert property (p_src) else $error("clock source changed while running");
  property p_osc_start;
    $rose(sysclk_en) && clk_src_sel inside {3'h2, 3'h3, 3'h4} |-> ev_cnt_r >= OSC_START_CYC;
  endproperty
  a_osc_start: assert property (p_osc_start) else $error("clock released before start-up timer");
  property p_pll; $rose(sysclk_en) && clk_src_sel inside {3'h1, 3'h3} |-> $past(pll_lock); endproperty
  a_pll: assert property (p_pll) else $error("clock released without lock");
  property p_release; $fell(core_reset) |-> code_exec_en && sysclk_en; endproperty
  a_release: assert property (p_release) else $error("reset released early");
  property p_clk_first; code_exec_en |-> sysclk_en && !core_reset; endproperty
  a_clk_first: assert property (p_clk_first) else $error("execution without clock");
  property p_reg; code_exec_en |-> reg_cnt_r >= REG_CYC; endproperty
  a_reg: assert property (p_reg) else $error("execution inside regulator start-up");
  property p_resume; power_resume |=> core_reset && !code_exec_en; endproperty
  a_resume: assert property (p_resume) else $error("resume did not hold reset");
  property p_bus; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest; endproperty
  a_bus: assert property (p_bus) else $error("bus answer not one cycle");
endmodule : brs_seq_chk

bind brs_seq brs_seq_chk #(.FSCM_CYC(FSCM_CYC), .OSC_START_CYC(OSC_START_CYC)) u_chk (.ref_clk(ref_clk), .rst(rst),
  .vdd_low(vdd_low), .power_resume(power_resume), .sleep_mode(sleep_mode), .idle_mode(idle_mode),
  .pll_lock(pll_lock), .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
  .core_reset(core_reset), .sysclk_en(sysclk_en), .code_exec_en(code_exec_en), .clk_src_sel(clk_src_sel));

`default_nettype wire

// ---- tb/brownout_reset_sequencer_tb_top.sv ----
// Purpose: Self-checking bench of the reset sequencer.
// Assumes: Short fail-safe and start-up counts; the regulator count stays at 2500 cycles.
// Notes: Release times are accepted within a few cycles of the longest pending delay.
`default_nettype none

module brownout_reset_sequencer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [2:0] sel; logic [1:0] mode; logic [19:0] dly; int wait_c;} brs_row_s;
  logic ref_clk = 1'b0, rst = 1'b1, dip = 1'b0, resume = 1'b0, sleep_mode = 1'b0, idle_mode = 1'b0;
  logic vdd_low, power_resume, pll_lock, avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
  logic core_reset, sysclk_en, code_exec_en, irq;
  logic [4:0] avs_address = 5'h00;
  logic [31:0] avs_writedata = 32'h00000000, avs_readdata, q;
  logic [2:0] clk_src_sel;
  int err_total = 0, check_count = 0, n;
  brs_row_s rows [9] = '{'{3'h0, 2'h0, 20'h0, 0}, '{3'h0, 2'h0, 20'h1E, 30}, '{3'h2, 2'h1, 20'h0, 20},
    '{3'h2, 2'h2, 20'h5, 8}, '{3'h4, 2'h0, 20'h0, 8}, '{3'h3, 2'h2, 20'h0, 20}, '{3'h1, 2'h0, 20'h0, 12},
    '{3'h2, 2'h0, 20'h0, 8}, '{3'h3, 2'h0, 20'h0, 12}};

  initial forever #4 ref_clk = ~ref_clk;

  brs_supply_model #(.LOCK_CYC(12)) u_far (.ref_clk(ref_clk), .rst(rst), .dip(dip), .resume(resume),
    .vdd_low(vdd_low), .power_resume(power_resume), .pll_lock(pll_lock));
  brs_seq #(.FSCM_CYC(20), .OSC_START_CYC(8)) dut (.ref_clk(ref_clk), .rst(rst), .vdd_low(vdd_low),
    .power_resume(power_resume), .sleep_mode(sleep_mode), .idle_mode(idle_mode), .pll_lock(pll_lock),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .core_reset(core_reset),
    .sysclk_en(sysclk_en), .code_exec_en(code_exec_en), .clk_src_sel(clk_src_sel), .irq(irq));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : final_report

  task automatic chk(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    check_count++;
    if (!(got >= lo && got <= hi) || $isunknown(got)) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask : chk

  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    // Waits for the answer however long it takes; the watchdog ends a hang.
    do begin
      @(posedge ref_clk);
    end while (avs_waitrequest !== 1'b0);
    r = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  // Raises a one-cycle dip or resume and counts edges until the core leaves reset.
  task automatic event_run(input logic res, output int c);
    @(posedge ref_clk);
    if (res) resume <= 1'b1;
    else dip <= 1'b1;
    @(posedge ref_clk);
    dip <= 1'b0;
    resume <= 1'b0;
    @(posedge ref_clk);
    c = 1;
    while (core_reset !== 1'b0 && c < 20000) begin
      @(posedge ref_clk);
      c++;
    end
  endtask : event_run

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    chk({core_reset, sysclk_en, code_exec_en, irq, avs_waitrequest}, 5'h11, 5'h11);
    n = 0;
    while (core_reset !== 1'b0 && n < 20000) begin
      @(posedge ref_clk);
      n++;
    end
    chk(n, 2500, 2510);
    $display("power-on test done");
    foreach (rows[i]) begin
      bus(1'b1, 5'h00, {27'h0, rows[i].mode, rows[i].sel}, q);
      bus(1'b1, 5'h04, {12'h0, rows[i].dly}, q);
      event_run(1'b0, n);
      chk(n, rows[i].wait_c + 2, rows[i].wait_c + 6);
      chk(clk_src_sel, rows[i].sel, rows[i].sel);
      bus(1'b0, 5'h08, 32'h0, q);
      chk(q & 32'h2, 32'h2, 32'h2);
      bus(1'b1, 5'h0C, 32'h7, q);
      $display("row %0d done", i);
    end
    bus(1'b1, 5'h00, 32'h0, q);
    bus(1'b1, 5'h10, 32'h2, q);
    sleep_mode <= 1'b1;
    idle_mode <= 1'b1;
    event_run(1'b0, n);
    chk(n, 2, 6);
    chk(irq, 1'b1, 1'b1);
    bus(1'b1, 5'h0C, 32'h2, q);
    repeat (2) @(posedge ref_clk);
    chk(irq, 1'b0, 1'b0);
    bus(1'b1, 5'h10, 32'h0, q);
    event_run(1'b0, n);
    repeat (2) @(posedge ref_clk);
    chk(irq, 1'b0, 1'b0);
    bus(1'b0, 5'h1C, 32'h0, q);
    chk(q, 32'h0, 32'h0);
    $display("interrupt and sleep test done");
    event_run(1'b1, n);
    chk(n, 2500, 2510);
    bus(1'b0, 5'h14, 32'h0, q);
    chk(q, 32'h3E, 32'h3E);
    bus(1'b0, 5'h08, 32'h0, q);
    chk(q, 32'h7, 32'h7);
    $display("resume test done");
    final_report();
  end

  initial begin
    repeat (40000) @(posedge ref_clk);
    err_total++;
    final_report();
  end
endmodule : brownout_reset_sequencer_tb_top

`default_nettype wire
